// ### src/fault_react.sv
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module fault_react #(
   parameter int WD_CYC = fault_react_pkg::WD_MAX_CYC,
   parameter int HALF = fault_react_pkg::HALF_CYC, parameter int HMIN = fault_react_pkg::HALF_MIN_CYC,
   parameter int HMAX = fault_react_pkg::HALF_MAX_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Round-robin diagnostics
   input  wire logic        rr_check,
   input  wire logic [3:0]  rr_fault,
   input  wire logic [15:0] cell_sum_mv,
   input  wire logic [15:0] block_mv,
   input  wire logic [9:0]  therm_result,
   input  wire logic [1:0]  therm_source,
   input  wire logic        crc_fault,
   input  wire logic        internal_error,
   // Power state
   input  wire logic        sleep_mode,
   input  wire logic        rr_sleep,
   output logic             wake_req,
   output logic             stay_awake,
   // Tone links and fault pin
   input  wire logic        rx_low_pin,
   input  wire logic        rx_high_pin,
   output logic             tx_low,
   output logic             tx_high,
   output logic             fault_pin,
   output logic             irq
);
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            old[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return old;
   endfunction

   logic [31:0] ctrl_reg;
   logic [7:0]  fault_reg;
   logic [7:0]  fmask_reg;
   logic [2:0]  istat_reg;
   logic [2:0]  imask_reg;
   logic [3:0]  cnt_reg [6];
   logic [31:0] wd_reg;
   logic        sleep_d_reg;
   logic        rxl_s1_reg, rxl_s2_reg, rxh_s1_reg, rxh_s2_reg;
   logic        en_low_reg, en_high_reg;
   logic        wr_go, wr_ok, rd_ok;
   logic [31:0] wmerged;
   logic [7:0]  fault_w1c, set_vec, new_set;
   logic [5:0]  hit;
   logic [16:0] diff;
   logic        therm_bad, cross_bad, sleep_rise;
   logic        det_low, det_high, tone_lvl, tone_busy, tone_done;
   logic        go_low, go_high, tone_start;
   logic [4:0]  need;

   // ---------------------------------------------
   // Bus slave
   // ---------------------------------------------
   assign wr_go   = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
   assign wr_ok   = s_axi_awaddr[1:0] == 2'h0 && (s_axi_awaddr == fault_react_pkg::CTRL_OFS
                    || s_axi_awaddr == fault_react_pkg::FAULT_OFS || s_axi_awaddr == fault_react_pkg::FMASK_OFS
                    || s_axi_awaddr == fault_react_pkg::ISTAT_OFS || s_axi_awaddr == fault_react_pkg::IMASK_OFS);
   assign wmerged = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
   assign fault_w1c = (wr_go && s_axi_awaddr == fault_react_pkg::FAULT_OFS) ? wmerged[7:0] : 8'h00;

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg  <= fault_react_pkg::CTRL_RST;
         fmask_reg <= fault_react_pkg::FMASK_RST;
         imask_reg <= fault_react_pkg::IMASK_RST;
      end else if (wr_go) begin
         if (s_axi_awaddr == fault_react_pkg::CTRL_OFS) begin
            ctrl_reg <= merge(ctrl_reg, s_axi_wdata, s_axi_wstrb);
         end
         if (s_axi_awaddr == fault_react_pkg::FMASK_OFS) begin
            fmask_reg <= 8'(merge({24'h0, fmask_reg}, s_axi_wdata, s_axi_wstrb));
         end
         if (s_axi_awaddr == fault_react_pkg::IMASK_OFS) begin
            imask_reg <= 3'(merge({29'h0, imask_reg}, s_axi_wdata, s_axi_wstrb));
         end
      end
   end

   assign rd_ok = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= fault_react_pkg::IMASK_OFS;

   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
            unique case (s_axi_araddr)
               fault_react_pkg::CTRL_OFS:   s_axi_rdata <= ctrl_reg;
               fault_react_pkg::FAULT_OFS:  s_axi_rdata <= {24'h0, fault_reg};
               fault_react_pkg::FMASK_OFS:  s_axi_rdata <= {24'h0, fmask_reg};
               fault_react_pkg::STATUS_OFS: s_axi_rdata <= {28'h0, stay_awake, wake_req, tone_busy, fault_pin};
               fault_react_pkg::ISTAT_OFS:  s_axi_rdata <= {29'h0, istat_reg};
               fault_react_pkg::IMASK_OFS:  s_axi_rdata <= {29'h0, imask_reg};
               default:                     s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Fault gathering
   // ---------------------------------------------
   assign diff      = {1'b0, cell_sum_mv} - {1'b0, block_mv};
   assign cross_bad = diff[16] ? (17'(-diff) > 17'(fault_react_pkg::CROSS_TH_MV))
                               : (diff > 17'(fault_react_pkg::CROSS_TH_MV));
   assign therm_bad = (therm_source == 2'h0 && therm_result <= 10'(fault_react_pkg::THERM_SHORT))
                   || (therm_source == 2'h3 && therm_result >= 10'(fault_react_pkg::THERM_OPEN));
   assign hit = {rr_fault[3], cross_bad, rr_fault[2:1], therm_bad, rr_fault[0]};

   always_comb begin
      set_vec = 8'h00;
      for (int i = 0; i < 6; i++) begin
         set_vec[i] = rr_check && hit[i] && cnt_reg[i] >= {1'b0, ctrl_reg[fault_react_pkg::CTRL_LIM_LSB +: 3]};
      end
      set_vec[fault_react_pkg::FLT_CRC] = crc_fault;
      set_vec[fault_react_pkg::FLT_INT] = internal_error;
   end

   assign new_set = set_vec & ~fault_reg & ~fmask_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < 6; i++) begin
            cnt_reg[i] <= 4'h0;
         end
         fault_reg <= 8'h00;
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (rr_check && hit[i] && cnt_reg[i] != 4'hF) begin
               cnt_reg[i] <= cnt_reg[i] + 4'h1;
            end else if (fault_w1c[i]) begin
               cnt_reg[i] <= 4'h0;
            end
         end
         fault_reg <= (fault_reg & ~fault_w1c) | set_vec;
      end
   end

   a_limit_exceed : assert property (@(posedge clk) disable iff (reset)
      rr_check && hit[0] && cnt_reg[0] < {1'b0, ctrl_reg[4:2]} && !fault_reg[0] |=> !fault_reg[0])
      else $error("fault set before limit");
   a_crc_direct : assert property (@(posedge clk) disable iff (reset)
      crc_fault |=> fault_reg[fault_react_pkg::FLT_CRC])
      else $error("crc fault not taken at once");

   // ---------------------------------------------
   // Fault pin and awake hold
   // ---------------------------------------------
   assign sleep_rise = sleep_mode && !sleep_d_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         sleep_d_reg <= 1'b0;
         fault_pin   <= 1'b0;
      end else begin
         sleep_d_reg <= sleep_mode;
         if (sleep_rise) begin
            fault_pin <= 1'b0;
         end else if (|new_set && !ctrl_reg[fault_react_pkg::CTRL_TONE_BIT]) begin
            fault_pin <= 1'b1;
         end else if ((fault_reg & ~fault_w1c & ~fmask_reg) == 8'h00) begin
            fault_pin <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wd_reg     <= 32'h0000_0000;
         stay_awake <= 1'b0;
      end else begin
         if (rr_sleep && |new_set && !ctrl_reg[fault_react_pkg::CTRL_TONE_BIT]) begin
            wd_reg     <= 32'(WD_CYC);
            stay_awake <= 1'b1;
         end else if (wd_reg != 32'h0000_0000) begin
            wd_reg     <= wd_reg - 32'h0000_0001;
            stay_awake <= wd_reg != 32'h0000_0001;
         end
      end
   end

   a_pin_masked : assert property (@(posedge clk) disable iff (reset)
      $rose(fault_pin) |-> $past(|(set_vec & ~fmask_reg)))
      else $error("pin raised by masked fault");
   a_pin_sleep : assert property (@(posedge clk) disable iff (reset)
      sleep_rise |=> !fault_pin)
      else $error("pin not released on sleep");
   a_awake_hold : assert property (@(posedge clk) disable iff (reset)
      rr_sleep && |new_set && !ctrl_reg[0] |=> stay_awake [*8])
      else $error("awake hold dropped early");

   // ---------------------------------------------
   // Tone links
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         rxl_s1_reg <= 1'b0;
         rxl_s2_reg <= 1'b0;
         rxh_s1_reg <= 1'b0;
         rxh_s2_reg <= 1'b0;
      end else begin
         rxl_s1_reg <= rx_low_pin;
         rxl_s2_reg <= rxl_s1_reg;
         rxh_s1_reg <= rx_high_pin;
         rxh_s2_reg <= rxh_s1_reg;
      end
   end

   assign need = wake_req ? 5'(fault_react_pkg::WAKE_DET) : 5'(fault_react_pkg::IDLE_DET);

   tone_det #(.HMIN(HMIN), .HMAX(HMAX)) det_low_i (
      .clk     (clk),
      .reset   (reset),
      .rx      (rxl_s2_reg),
      .need    (need),
      .det_reg (det_low)
   );

   tone_det #(.HMIN(HMIN), .HMAX(HMAX)) det_high_i (
      .clk     (clk),
      .reset   (reset),
      .rx      (rxh_s2_reg),
      .need    (need),
      .det_reg (det_high)
   );

   // Own fault goes both ways; forwarded tone to opposite side
   assign go_low  = (|new_set && ctrl_reg[fault_react_pkg::CTRL_TONE_BIT])
                 || (det_high && (sleep_mode || !ctrl_reg[fault_react_pkg::CTRL_DIR_BIT]));
   assign go_high = (|new_set && ctrl_reg[fault_react_pkg::CTRL_TONE_BIT])
                 || (det_low && (sleep_mode || ctrl_reg[fault_react_pkg::CTRL_DIR_BIT]));
   assign tone_start = (go_low || go_high) && !tone_busy;

   tone_tx #(.HALF(HALF)) tx_i (
      .clk       (clk),
      .reset     (reset),
      .start     (tone_start),
      .level_reg (tone_lvl),
      .busy_reg  (tone_busy),
      .done_reg  (tone_done)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         en_low_reg  <= 1'b0;
         en_high_reg <= 1'b0;
         tx_low      <= 1'b0;
         tx_high     <= 1'b0;
         wake_req    <= 1'b0;
      end else begin
         if (tone_start) begin
            en_low_reg  <= go_low;
            en_high_reg <= go_high;
         end
         tx_low  <= tone_lvl && en_low_reg;
         tx_high <= tone_lvl && en_high_reg;
         if (sleep_mode && (det_low || det_high)) begin
            wake_req <= 1'b1;
         end else if (tone_done) begin
            wake_req <= 1'b0;
         end
      end
   end

   sequence s_det_sleep;
      sleep_mode && (det_low || det_high) && !tone_busy;
   endsequence
   sequence s_tx_up;
      ##1 wake_req && tone_busy;
   endsequence
   a_sleep_fwd : assert property (@(posedge clk) disable iff (reset)
      s_det_sleep |-> s_tx_up)
      else $error("sleep tone not forwarded");
   a_no_back_fwd : assert property (@(posedge clk) disable iff (reset)
      det_low && !sleep_mode && !ctrl_reg[1] && !(|new_set) && !tone_busy |=> !tone_busy)
      else $error("tone forwarded away from host");

   // ---------------------------------------------
   // Interrupts
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         istat_reg <= 3'h0;
         irq       <= 1'b0;
      end else begin
         istat_reg <= (istat_reg & ~((wr_go && s_axi_awaddr == fault_react_pkg::ISTAT_OFS) ? wmerged[2:0] : 3'h0))
                    | {tone_done, det_low || det_high, |new_set};
         irq       <= |(istat_reg & imask_reg);
      end
   end
endmodule

// ### src/fault_react_pkg.sv
package fault_react_pkg;
   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam int CLK_KHZ      = 200000;
   localparam int TONE_KHZ     = 50;
   localparam int TONE_MIN_KHZ = 48;
   localparam int TONE_MAX_KHZ = 52;
   localparam int HALF_CYC     = CLK_KHZ / (2 * TONE_KHZ);
   localparam int HALF_MIN_CYC = (CLK_KHZ + 2 * TONE_MAX_KHZ - 1) / (2 * TONE_MAX_KHZ);
   localparam int HALF_MAX_CYC = CLK_KHZ / (2 * TONE_MIN_KHZ);
   localparam int WD_MAX_MS    = 1000;
   localparam int WD_MAX_CYC   = WD_MAX_MS * CLK_KHZ;
   // ---------------------------------------------
   // Counts and limits
   // ---------------------------------------------
   localparam int TX_PERIODS    = 32;
   localparam int IDLE_DET      = 16;
   localparam int WAKE_DET      = 4;
   localparam int CROSS_TH_MV   = 256;
   localparam int THERM_SHORT   = 64;
   localparam int THERM_OPEN    = 1023;
   // ---------------------------------------------
   // Register map
   // ---------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] FAULT_OFS  = 8'h04;
   localparam logic [7:0] FMASK_OFS  = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] ISTAT_OFS  = 8'h10;
   localparam logic [7:0] IMASK_OFS  = 8'h14;
   localparam int CTRL_TONE_BIT  = 0;
   localparam int CTRL_DIR_BIT   = 1;
   localparam int CTRL_LIM_LSB   = 2;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [7:0]  FMASK_RST = 8'h00;
   localparam logic [2:0]  IMASK_RST = 3'h0;
   localparam int FLT_THERM = 1;
   localparam int FLT_CROSS = 4;
   localparam int FLT_CRC   = 6;
   localparam int FLT_INT   = 7;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_DET   = 1;
   localparam int IRQ_DONE  = 2;
endpackage

// ### src/tone_det.sv
`timescale 1ns/100ps
module tone_det #(
   parameter int HMIN = fault_react_pkg::HALF_MIN_CYC,
   parameter int HMAX = fault_react_pkg::HALF_MAX_CYC
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Line and threshold
   input  wire logic       rx,
   input  wire logic [4:0] need,
   output logic            det_reg
);
   logic        rx_d_reg;
   logic [11:0] gap_reg;
   logic [5:0]  good_reg;
   logic        edge_seen;
   logic        gap_ok;

   assign edge_seen = rx ^ rx_d_reg;
   assign gap_ok    = gap_reg >= 12'(HMIN - 1) && gap_reg <= 12'(HMAX - 1);

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_d_reg <= 1'b0;
         gap_reg  <= 12'h000;
         good_reg <= 6'h00;
         det_reg  <= 1'b0;
      end else begin
         rx_d_reg <= rx;
         det_reg  <= 1'b0;
         if (edge_seen) begin
            gap_reg <= 12'h000;
            if (!gap_ok) begin
               good_reg <= 6'h00;
            end else if (good_reg + 6'h01 >= {need, 1'b0}) begin
               good_reg <= 6'h00;
               det_reg  <= 1'b1;
            end else begin
               good_reg <= good_reg + 6'h01;
            end
         end else if (gap_reg != 12'hFFF) begin
            gap_reg <= gap_reg + 12'h001;
         end
         if (!edge_seen && gap_reg > 12'(HMAX)) begin
            good_reg <= 6'h00;
         end
      end
   end

   a_det_needs : assert property (@(posedge clk) disable iff (reset)
      det_reg |-> $past(gap_ok) && $past(edge_seen))
      else $error("detect without valid edge");
endmodule

// ### src/tone_tx.sv
`timescale 1ns/100ps
module tone_tx #(
   parameter int HALF    = fault_react_pkg::HALF_CYC,
   parameter int PERIODS = fault_react_pkg::TX_PERIODS
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Control
   input  wire logic start,
   output logic      level_reg,
   output logic      busy_reg,
   output logic      done_reg
);
   logic [11:0] half_reg;
   logic [7:0]  edge_reg;
   logic [31:0] run_cnt_reg;
   logic [31:0] per_cnt_reg;
   logic        lvl_d_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         half_reg  <= 12'h000;
         edge_reg  <= 8'h00;
         level_reg <= 1'b0;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (!busy_reg) begin
            if (start) begin
               busy_reg  <= 1'b1;
               level_reg <= 1'b1;
               half_reg  <= 12'h000;
               edge_reg  <= 8'h00;
            end
         end else if (half_reg == 12'(HALF - 1)) begin
            half_reg <= 12'h000;
            if (edge_reg == 8'(2 * PERIODS - 1)) begin
               busy_reg  <= 1'b0;
               level_reg <= 1'b0;
               done_reg  <= 1'b1;
            end else begin
               level_reg <= ~level_reg;
               edge_reg  <= edge_reg + 8'h01;
            end
         end else begin
            half_reg <= half_reg + 12'h001;
         end
      end
   end

   // Burst length and period counters for checks
   always_ff @(posedge clk) begin
      if (reset) begin
         run_cnt_reg <= 32'h0000_0000;
         per_cnt_reg <= 32'h0000_0000;
         lvl_d_reg   <= 1'b0;
      end else begin
         run_cnt_reg <= busy_reg ? run_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
         per_cnt_reg <= (level_reg && !lvl_d_reg) ? 32'h0000_0001 : per_cnt_reg + 32'h0000_0001;
         lvl_d_reg   <= level_reg;
      end
   end

   a_tx_length : assert property (@(posedge clk) disable iff (reset)
      $fell(busy_reg) |-> run_cnt_reg == 32'(2 * PERIODS * HALF))
      else $error("tone burst length wrong");
   a_tx_rises : assert property (@(posedge clk) disable iff (reset)
      level_reg && !lvl_d_reg && edge_reg != 8'h00 |-> per_cnt_reg == 32'(2 * HALF))
      else $error("tone period wrong");
endmodule

// ### tb/emergency_signal_fault_output_test.sv
`timescale 1ns/100ps
module emergency_signal_fault_output_test;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic        clk = 1'h0, reset = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr_ = 1'h0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdat, lfsr = 32'hE5D21CB6;
   logic        awr, wr_, bv, arr, rv, wake, stay, txl, txh, pin, irq, rxl, txl_d = 1'h0, txh_d = 1'h0;
   logic [1:0]  bresp, rresp, rsp, tsrc = 2'h1;
   logic [31:0] rd_;
   logic [3:0]  rrf = 4'h0;
   logic [15:0] csum = 16'h0, bmv = 16'h0;
   logic [9:0]  tres = 10'h1F4;
   logic        rrc = 1'h0, crc = 1'h0, ierr = 1'h0, slp = 1'h0, rrs = 1'h0, tgo = 1'h0;
   int          err_count = 0, comparisons = 0, cyc = 0, lo_r = 0, hi_r = 0, prev = 0, flt = 0;
   localparam int H = 50;
   always #2.5 clk = ~clk;
   fault_react #(.WD_CYC(50), .HALF(H), .HMIN(45), .HMAX(55)) u_fault_react (
      .clk(clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd_), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr_), .rr_check(rrc),
      .rr_fault(rrf), .cell_sum_mv(csum), .block_mv(bmv), .therm_result(tres), .therm_source(tsrc),
      .crc_fault(crc), .internal_error(ierr), .sleep_mode(slp), .rr_sleep(rrs), .wake_req(wake),
      .stay_awake(stay), .rx_low_pin(rxl), .rx_high_pin(1'h0), .tx_low(txl), .tx_high(txh),
      .fault_pin(pin), .irq(irq));
   tone_source #(.HALF(H)) u_tone_source (.clk(clk), .start(tgo), .periods(6'h20), .line(rxl));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      @(posedge clk);
      while (!awr) @(posedge clk);
      awv <= 1'h0;
      wv <= 1'h0;
      while (!bv) @(posedge clk);
      br <= 1'h0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rr_ <= 1'h1;
      @(posedge clk);
      while (!arr) @(posedge clk);
      arv <= 1'h0;
      while (!rv) @(posedge clk);
      rdat = rd_;
      rsp = rresp;
      rr_ <= 1'h0;
      check(rdat, exp);
   endtask
   task automatic rr(input logic [3:0] f, input logic [15:0] cs, input logic [9:0] tr, input logic [1:0] ts);
      @(posedge clk);
      rrf <= f;
      csum <= cs;
      tres <= tr;
      tsrc <= ts;
      rrc <= 1'h1;
      @(posedge clk);
      rrc <= 1'h0;
      rrf <= 4'h0;
      tres <= 10'h1F4;
      tsrc <= 2'h1;
      csum <= bmv;
      wt(3);
   endtask
   task automatic diag(input logic [15:0] cs, input logic [9:0] tr, input logic [1:0] ts, input int e);
      rr(4'h0, cs, tr, ts);
      rdchk(fault_react_pkg::FAULT_OFS, 32'(e));
      wr(fault_react_pkg::FAULT_OFS, 32'hFF);
   endtask
   task automatic strike(input logic internal);
      @(posedge clk);
      if (internal) ierr <= 1'h1;
      else crc <= 1'h1;
      @(posedge clk);
      ierr <= 1'h0;
      crc <= 1'h0;
   endtask
   // ---------------------------------------------
   // Timeout and tone edge watch
   // ---------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      txl_d <= txl;
      txh_d <= txh;
      if (txl && !txl_d) lo_r <= lo_r + 1;
      if (txh && !txh_d) begin
         hi_r <= hi_r + 1;
         prev <= cyc;
         if (prev != 0 && cyc - prev < 8 * H) check(32'(cyc - prev), 32'(2 * H));
      end
      if (cyc == 50000) begin
         err_count++;
         end_of_test;
      end
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      bmv = {4'h0, lfsr[11:0]} + 16'h0400;
      csum = bmv;
      wt(5);
      reset <= 1'h0;
      rdchk(fault_react_pkg::CTRL_OFS, fault_react_pkg::CTRL_RST);
      rdchk(fault_react_pkg::FMASK_OFS, 32'(fault_react_pkg::FMASK_RST));
      rdchk(8'h40, 32'h0);
      check(rsp, 2'h2);
      $display("reset values done");
      wr(fault_react_pkg::IMASK_OFS, 32'h1);
      strike(1'h0);
      wt(3);
      check(pin, 1'h1);
      check(irq, 1'h1);
      flt = 32'h40;
      rdchk(fault_react_pkg::FAULT_OFS, 32'(flt));
      wr(fault_react_pkg::ISTAT_OFS, 32'h1);
      wt(2);
      check(irq, 1'h0);
      slp <= 1'h1;
      wt(3);
      check(pin, 1'h0);
      slp <= 1'h0;
      wr(fault_react_pkg::FAULT_OFS, 32'hFF);
      wr(fault_react_pkg::FMASK_OFS, 32'h80);
      strike(1'h1);
      wt(3);
      check(pin, 1'h0);
      check(irq, 1'h0);
      wr(fault_react_pkg::FAULT_OFS, 32'hFF);
      wr(fault_react_pkg::FMASK_OFS, 32'h0);
      $display("pin and mask done");
      wr(fault_react_pkg::CTRL_OFS, 32'h8);
      rr(4'h1, bmv, 10'h1F4, 2'h1);
      rr(4'h1, bmv, 10'h1F4, 2'h1);
      rdchk(fault_react_pkg::FAULT_OFS, 32'h0);
      rr(4'h1, bmv, 10'h1F4, 2'h1);
      rdchk(fault_react_pkg::FAULT_OFS, 32'h1);
      wr(fault_react_pkg::FAULT_OFS, 32'hFF);
      wr(fault_react_pkg::CTRL_OFS, 32'h0);
      diag(bmv + 16'd256, 10'h1F4, 2'h1, 0);
      diag(bmv + 16'd257, 10'h1F4, 2'h1, 32'h10);
      diag(bmv - 16'd257, 10'h1F4, 2'h1, 32'h10);
      diag(bmv, 10'h040, 2'h0, 32'h2);
      diag(bmv, 10'h041, 2'h0, 0);
      diag(bmv, 10'h3FF, 2'h3, 32'h2);
      diag(bmv, 10'h3FE, 2'h3, 0);
      $display("counting and diagnostics done");
      rrs <= 1'h1;
      rr(4'h1, bmv, 10'h1F4, 2'h1);
      check(stay, 1'h1);
      wt(60);
      check(stay, 1'h0);
      rrs <= 1'h0;
      wr(fault_react_pkg::FAULT_OFS, 32'hFF);
      wr(fault_react_pkg::CTRL_OFS, 32'h1);
      lo_r <= 0;
      hi_r <= 0;
      strike(1'h0);
      wt(33 * 2 * H);
      check(hi_r, 32'(fault_react_pkg::TX_PERIODS));
      check(lo_r, 32'(fault_react_pkg::TX_PERIODS));
      check(pin, 1'h0);
      $display("tone burst done");
      reset <= 1'h1;
      wt(2);
      reset <= 1'h0;
      slp <= 1'h1;
      lo_r <= 0;
      hi_r <= 0;
      tgo <= 1'h1;
      wt(1);
      tgo <= 1'h0;
      wt(15 * 2 * H);
      check(wake, 1'h0);
      wt(4 * 2 * H);
      check(wake, 1'h1);
      wt(6000);
      check(hi_r, 32'(fault_react_pkg::TX_PERIODS));
      check(lo_r, 0);
      check(wake, 1'h0);
      rdchk(fault_react_pkg::ISTAT_OFS, 32'h6);
      $display("sleep forwarding done");
      end_of_test;
   end
endmodule

// ### tb/tone_source.sv
`timescale 1ns/100ps
module tone_source #(
   parameter int HALF = fault_react_pkg::HALF_CYC
) (
   // Clock and control
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic [5:0] periods,
   // Link line
   output logic            line
);
   logic level = 1'h0;
   int   half_left = 0;
   int   edges_left = 0;
   assign line = level;
   // ---------------------------------------------
   // Square wave burst, starting high
   // ---------------------------------------------
   always @(posedge clk) begin
      if (start && edges_left == 0) begin
         level <= 1'h1;
         edges_left <= 2 * periods - 1;
         half_left <= HALF - 1;
      end else if (edges_left != 0) begin
         if (half_left == 0) begin
            level <= ~level;
            edges_left <= edges_left - 1;
            half_left <= HALF - 1;
         end else begin
            half_left <= half_left - 1;
         end
      end
   end
endmodule
